// ===== bench/serial_bus_master.sv
`timescale 1ns/100ps

// ==========
// Two-wire master model
module serial_bus_master (
   input  wire logic linkClock,
   input  wire logic sdaLine,
   output logic      scl,
   output logic      sdaLow
);
   // Long phases let the device's synchroniser see every level.
   localparam int HALF = 20;

   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge linkClock);
   endtask

   task automatic start();
      ticks(HALF);
      sdaLow <= 1'b1;
      ticks(HALF);
      scl <= 1'b0;
   endtask

   task automatic sendByte(input logic [7:0] b, output logic ack, output logic clash);
      clash = 1'b0;
      ack = 1'b0;
      for (int i = 7; i >= -1; i--) begin
         ticks(HALF / 2);
         sdaLow <= (i >= 0) ? ~b[i] : 1'b0;
         ticks(HALF / 2);
         scl <= 1'b1;
         ticks(HALF / 2);
         if (i >= 0 && sdaLine !== b[i]) begin
            clash = 1'b1;
         end
         if (i < 0) begin
            ack = ~sdaLine;
         end
         ticks(HALF / 2);
         scl <= 1'b0;
      end
   endtask

   task automatic stop();
      ticks(HALF / 2);
      sdaLow <= 1'b1;
      ticks(HALF / 2);
      scl <= 1'b1;
      ticks(HALF);
      sdaLow <= 1'b0;
      ticks(HALF);
   endtask
endmodule

// ===== bench/test_dual_wiper_serial_write_port.sv
`timescale 1ns/100ps
`include "dual_wiper_defines.svh"

module test_dual_wiper_serial_write_port;
   logic        clock, rst, linkClock, scl, sdaLow, sdaLine;
   logic        strap0, strap1, strap2, serialDataOut, serialDataOe;
   logic [7:0]  wiperA, wiperB, refA, refB, own, data;
   logic [15:0] lfsrQ;
   logic [15:0] expQ[$];
   logic [7:0]  cmds[3] = '{`CMD_CHAN_A, `CMD_CHAN_B, `CMD_CHAN_AB};
   int          errors, compares;
   event        noteReady;

   // The data line has a pull-up; either party may only pull it low.
   assign sdaLine = ~(sdaLow | (serialDataOe & ~serialDataOut));

   dual_wiper_serial_write_port i_dut (
      .clock(clock), .rst(rst), .serialClock(scl), .serialDataIn(sdaLine),
      .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
      .addr_strap_bit0(strap0), .addr_strap_bit1(strap1), .addr_strap_bit2(strap2),
      .chan_a_wiper_out(wiperA), .chan_b_wiper_out(wiperB));

   serial_bus_master i_master (
      .linkClock(linkClock), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

   // ==========
   // Helpers
   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic close_out();
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic note();
      expQ.push_back({refA, refB});
      ->noteReady;
   endtask

   // one framed write; full clear means STOP right after the command.
   task automatic xfer(input logic [7:0] addr, cmd, dat, input logic full);
      logic ack, clash, hit, ok;
      hit = (addr[7:1] == own[7:1]);
      ok = hit && !addr[0];
      i_master.start();
      i_master.sendByte(addr, ack, clash);
      check(16'({ack, clash}), 16'({hit, 1'b0}));
      i_master.sendByte(cmd, ack, clash);
      check(16'({ack, clash}), 16'({ok, 1'b0}));
      if (full) begin
         i_master.sendByte(dat, ack, clash);
         check(16'({ack, clash}), 16'({ok, 1'b0}));
      end
      i_master.stop();
      if (ok && full && (cmd == `CMD_CHAN_A || cmd == `CMD_CHAN_AB)) begin
         refA = dat;
      end
      if (ok && full && (cmd == `CMD_CHAN_B || cmd == `CMD_CHAN_AB)) begin
         refB = dat;
      end
      note();
   endtask

   // ==========
   // Clocks, monitor and watchdog
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      linkClock = 1'b0;
      #3.7;
      forever #6 linkClock = ~linkClock;
   end

   initial begin
      forever begin
         @(noteReady);
         @(negedge clock);
         check({wiperA, wiperB}, expQ.pop_front());
      end
   end

   initial begin
      #2000000;
      errors++;
      close_out();
   end

   // ==========
   // Main sequence
   initial begin
      errors = 0;
      compares = 0;
      lfsrQ = 16'hff53;
      rst = 1'b1;
      {strap2, strap1, strap0} = lfsrQ[2:0];
      own = {`SLAVE_ADDR_FIXED, lfsrQ[2:0], 1'b0};
      refA = `WIPER_MIDSCALE;
      refB = `WIPER_MIDSCALE;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      note();
      for (int i = 0; i < 9; i++) begin
         lfsrQ = lfsrNext(lfsrQ);
         data = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsrQ[7:0];
         xfer(own, cmds[i % 3], data, 1'b1);
      end
      lfsrQ = lfsrNext(lfsrQ);
      xfer(own ^ 8'h02, `CMD_CHAN_AB, lfsrQ[7:0], 1'b1);
      xfer(own ^ 8'h80, `CMD_CHAN_AB, lfsrQ[15:8], 1'b1);
      xfer(own | 8'h01, `CMD_CHAN_AB, lfsrQ[7:0], 1'b1);
      xfer(own, 8'h14, lfsrQ[15:8], 1'b1);
      xfer(own, `CMD_CHAN_AB, lfsrQ[7:0], 1'b0);
      xfer(own, `CMD_CHAN_B, lfsrQ[15:8], 1'b1);
      repeat (4) @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      refA = `WIPER_MIDSCALE;
      refB = `WIPER_MIDSCALE;
      repeat (6) @(posedge clock);
      note();
      xfer(own, `CMD_CHAN_A, lfsrQ[7:0], 1'b1);
      repeat (4) @(posedge clock);
      check(16'(expQ.size()), 16'h0000);
      close_out();
   end
endmodule

// ===== design/dual_wiper_defines.svh
`ifndef DUAL_WIPER_DEFINES_SVH
`define DUAL_WIPER_DEFINES_SVH

// =============================================================
// Wiper values
`define WIPER_MIDSCALE     8'h80

// =============================================================
// Address and command codes
`define SLAVE_ADDR_FIXED   4'h5
`define CMD_CHAN_A         8'h11
`define CMD_CHAN_B         8'h12
`define CMD_CHAN_AB        8'h13

// =============================================================
// Byte framing counts
`define BITS_PER_BYTE      4'h8
`define LAST_DATA_BIT      4'h7

`endif

// ===== design/dual_wiper_pkg.sv
package dual_wiper_pkg;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_ADDR   = 3'b001,
      ST_CMD    = 3'b010,
      ST_DATA   = 3'b011,
      ST_IGNORE = 3'b100
   } link_state_t;

endpackage

// ===== design/dual_wiper_serial_write_port.sv
// Summary of operation
// - Each wiper register: 8 bits, 256 taps
// - Channels keep separate position registers
// - Stored data byte moves wiper at once
// - Reset loads both wipers with midscale
// - Slave only; master makes all clocks
// - Data pin open-drain, clock input only
// - Start and stop detected while clock high
// - One bit per clock, stable while high
// - Ninth clock: device holds data low
// - Direction bit high means no operation
// - No read path; only acknowledge driven
// - Address is 0101 plus three straps
// - First byte is command, next data
// - Command 11h loads channel A
// - Command 12h loads channel B only
// - Command 13h loads both channels
`timescale 1ns/100ps
`include "dual_wiper_defines.svh"

module dual_wiper_serial_write_port
   import dual_wiper_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       serialClock,
   input  wire logic       serialDataIn,
   output logic            serialDataOut,
   output logic            serialDataOe,
   input  wire logic       addr_strap_bit0,
   input  wire logic       addr_strap_bit1,
   input  wire logic       addr_strap_bit2,
   output logic [7:0]      chan_a_wiper_out,
   output logic [7:0]      chan_b_wiper_out
);

   // =============================================================
   // Link domain: bits are captured on the master's clock edge
   logic [7:0]  shiftQ;

   // The master holds data stable through the high phase, so the rising edge is safe.
   // master-clocked link
   always_ff @(posedge serialClock or posedge rst) begin
      if (rst) begin
         shiftQ <= 8'h00;
      end else begin
         shiftQ <= {shiftQ[6:0], serialDataIn};
      end
   end

   // =============================================================
   // Pin synchronisers and filtered levels
   logic [2:0]  sclSyncQ;
   logic [2:0]  sdaSyncQ;
   logic        sclLevelQ;
   logic        sdaLevelQ;
   logic [2:0]  strapMetaQ;
   logic [2:0]  strapMidQ;
   logic [2:0]  strapLateQ;
   logic [2:0]  strapQ;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclSyncQ  <= 3'h7;
         sdaSyncQ  <= 3'h7;
         sclLevelQ <= 1'b1;
         sdaLevelQ <= 1'b1;
      end else begin
         sclSyncQ <= {sclSyncQ[1:0], serialClock};
         sdaSyncQ <= {sdaSyncQ[1:0], serialDataIn};
         if (sclSyncQ[1] == sclSyncQ[2]) begin
            sclLevelQ <= sclSyncQ[2];
         end
         if (sdaSyncQ[1] == sdaSyncQ[2]) begin
            sdaLevelQ <= sdaSyncQ[2];
         end
      end
   end

   // Straps are tied off on the board; they are caught a few cycles after reset release.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strapMetaQ <= 3'h0;
         strapMidQ  <= 3'h0;
         strapLateQ <= 3'h0;
         strapQ     <= 3'h0;
      end else begin
         strapMetaQ <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
         strapMidQ  <= strapMetaQ;
         strapLateQ <= strapMidQ;
         if (strapMidQ == strapLateQ) begin
            strapQ <= strapLateQ;
         end
      end
   end

   logic sclAgree;
   logic sdaAgree;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;

   assign sclAgree = (sclSyncQ[1] == sclSyncQ[2]);
   assign sdaAgree = (sdaSyncQ[1] == sdaSyncQ[2]);
   assign sclRise  = sclAgree && sclSyncQ[2] && !sclLevelQ;
   assign sclFall  = sclAgree && !sclSyncQ[2] && sclLevelQ;
   assign startEv  = sclLevelQ && sclAgree && sclSyncQ[2] && sdaAgree && !sdaSyncQ[2] && sdaLevelQ;
   assign stopEv   = sclLevelQ && sclAgree && sclSyncQ[2] && sdaAgree && sdaSyncQ[2] && !sdaLevelQ;

   // =============================================================
   // Byte framing
   link_state_t stateQ;
   logic [3:0]  bitCntQ;
   logic [7:0]  cmdQ;
   logic        ackPendQ;
   logic        sdaOeQ;
   logic        byteDone;
   logic        addrMatch;

   // The synchronised rise lags the real edge by several cycles, and the
   // shift register then stays still until the next rise, so reading it here
   // is a safe word crossing without a separate handshake.
   assign byteDone  = sclRise && (bitCntQ == `LAST_DATA_BIT) &&
                      (stateQ != ST_IDLE) && (stateQ != ST_IGNORE);
   assign addrMatch = (shiftQ[7:4] == `SLAVE_ADDR_FIXED) && (shiftQ[3:1] == strapQ);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stateQ <= ST_IDLE;
      end else if (startEv) begin
         stateQ <= ST_ADDR;
      end else if (stopEv) begin
         stateQ <= ST_IDLE;
      end else if (byteDone) begin
         unique case (stateQ)
            ST_ADDR: begin
               stateQ <= (addrMatch && !shiftQ[0]) ? ST_CMD : ST_IGNORE;
            end
            ST_CMD: begin
               stateQ <= ST_DATA;
            end
            default: begin
               stateQ <= stateQ;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bitCntQ <= 4'h0;
      end else if (startEv) begin
         bitCntQ <= 4'h0;
      end else if (sclRise) begin
         bitCntQ <= (bitCntQ == `BITS_PER_BYTE) ? 4'h0 : bitCntQ + 4'h1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmdQ <= 8'h00;
      end else if (byteDone && stateQ == ST_CMD) begin
         cmdQ <= shiftQ;
      end
   end

   // A matched but no-operation address is still acknowledged.
   // acknowledge only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ackPendQ <= 1'b0;
      end else if (startEv || stopEv) begin
         ackPendQ <= 1'b0;
      end else if (byteDone) begin
         ackPendQ <= (stateQ != ST_ADDR) || addrMatch;
      end else if (sclFall) begin
         ackPendQ <= 1'b0;
      end
   end

   // Driving on the fall keeps the line steady through the whole ninth high phase.
   // open-drain drive
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sdaOeQ <= 1'b0;
      end else if (startEv || stopEv) begin
         sdaOeQ <= 1'b0;
      end else if (sclFall) begin
         sdaOeQ <= ackPendQ;
      end
   end

   assign serialDataOe = sdaOeQ;

   // The pin only ever pulls low; the output level is a constant flop.
   logic sdaLowQ;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sdaLowQ <= 1'b0;
      end else begin
         sdaLowQ <= 1'b0;
      end
   end
   assign serialDataOut = sdaLowQ;

   // =============================================================
   // Wiper registers
   logic dataDone;
   logic wrA;
   logic wrB;

   // Bytes after the data byte are written again with the same command.
   assign dataDone = byteDone && (stateQ == ST_DATA);
   assign wrA = dataDone && ((cmdQ == `CMD_CHAN_A) || (cmdQ == `CMD_CHAN_AB));
   assign wrB = dataDone && ((cmdQ == `CMD_CHAN_B) || (cmdQ == `CMD_CHAN_AB));

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chan_a_wiper_out <= `WIPER_MIDSCALE;
      end else if (wrA) begin
         chan_a_wiper_out <= shiftQ;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chan_b_wiper_out <= `WIPER_MIDSCALE;
      end else if (wrB) begin
         chan_b_wiper_out <= shiftQ;
      end
   end

   // =============================================================
   // Checks
   property p_write_a;
      @(posedge clock) disable iff (rst)
      wrA |=> (chan_a_wiper_out == $past(shiftQ));
   endproperty
   a_write_a: assert property (p_write_a) else $error("Wiper A missed its data byte.");

   property p_b_holds;
      @(posedge clock) disable iff (rst)
      (dataDone && cmdQ == `CMD_CHAN_A) |=> $stable(chan_b_wiper_out);
   endproperty
   a_b_holds: assert property (p_b_holds) else $error("Wiper B changed on an A write.");

   property p_both;
      @(posedge clock) disable iff (rst)
      (dataDone && cmdQ == `CMD_CHAN_AB) |=> (chan_a_wiper_out == chan_b_wiper_out);
   endproperty
   a_both: assert property (p_both) else $error("Combined write left wipers unequal.");

   property p_only_on_write;
      @(posedge clock) disable iff (rst)
      !$stable(chan_a_wiper_out) |-> $past(wrA);
   endproperty
   a_only_on_write: assert property (p_only_on_write) else $error("Wiper A moved unasked.");

   property p_bad_cmd;
      @(posedge clock) disable iff (rst)
      (dataDone && cmdQ != `CMD_CHAN_A && cmdQ != `CMD_CHAN_B && cmdQ != `CMD_CHAN_AB)
      |=> ($stable(chan_a_wiper_out) && $stable(chan_b_wiper_out));
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("Unknown command moved a wiper.");

   property p_reset_mid;
      @(posedge clock) disable iff (rst)
      $past(rst) |-> (chan_a_wiper_out == `WIPER_MIDSCALE && chan_b_wiper_out == `WIPER_MIDSCALE);
   endproperty
   a_reset_mid: assert property (p_reset_mid) else $error("Wipers not midscale after reset.");

   property p_never_high;
      @(posedge clock) disable iff (rst)
      serialDataOe |-> !serialDataOut;
   endproperty
   a_never_high: assert property (p_never_high) else $error("Data pin driven high.");

   property p_ack_slot;
      @(posedge clock) disable iff (rst)
      $rose(sdaOeQ) |-> (bitCntQ == `BITS_PER_BYTE);
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("Data pin driven outside ack slot.");

   property p_ack_held;
      @(posedge clock) disable iff (rst)
      (sclRise && bitCntQ == `BITS_PER_BYTE && sdaOeQ && !startEv && !stopEv) |=> sdaOeQ;
   endproperty
   a_ack_held: assert property (p_ack_held) else $error("Ack released during ninth clock.");

   property p_nop;
      @(posedge clock) disable iff (rst)
      (byteDone && stateQ == ST_ADDR && shiftQ[0] && !startEv && !stopEv)
      |=> (stateQ == ST_IGNORE);
   endproperty
   a_nop: assert property (p_nop) else $error("No-operation address went on to write.");

   property p_foreign;
      @(posedge clock) disable iff (rst)
      (byteDone && stateQ == ST_ADDR && !addrMatch && !startEv && !stopEv)
      |=> (stateQ == ST_IGNORE && !ackPendQ);
   endproperty
   a_foreign: assert property (p_foreign) else $error("Foreign address accepted.");

   // A no-operation address is acknowledged and then ignored; only a foreign
   // address must leave the line untouched, so the two are told apart here.
   logic foreignQ;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         foreignQ <= 1'b0;
      end else if (startEv || stopEv) begin
         foreignQ <= 1'b0;
      end else if (byteDone && stateQ == ST_ADDR) begin
         foreignQ <= !addrMatch;
      end
   end

   property p_ignore_quiet;
      @(posedge clock) disable iff (rst)
      (stateQ == ST_IGNORE && foreignQ) |-> !sdaOeQ;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet) else $error("Ack while ignoring.");

   property p_start;
      @(posedge clock) disable iff (rst)
      startEv |=> (stateQ == ST_ADDR && bitCntQ == 4'h0 && !sdaOeQ);
   endproperty
   a_start: assert property (p_start) else $error("Start did not restart framing.");

endmodule
